// ---- rtl/arpt_top.sv ----
// Function
// [R1] count steps once per selected counter tick
// [R2] count resets to zero, read only
// [R3] software reads count as two bytes
// [R4] overflow reloads count from reload value
// [R5] reload value split into high, low bytes
// [R6] software writes duty high byte first
// [R7] drive enable picks waveform or compare use
// [R8] invert bit one of output status
// [R9] match flag set on equality, read clears
// [R10] drive enable bit routes waveform to pin
// [R11] software writes zeros to reserved bits
// [R12] reset clears all timer registers
// [R13] wrap reloads, refreshes shadow, raises output
// [R14] high duty write locks comparison until low
// [R15] wrap flag on top to reload, read clears
// [R16] two bit counter clock selection field
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// autoreload timer with axi4-lite register access
// ==========================================================
module arpt_top (
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // axi write address
  input wire logic [11:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  // axi write data
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  // axi write response
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  // axi read address
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  // axi read data
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // millisecond timebase from outside
  input wire logic ms_tick_in,
  // waveform pin
  output logic modulated_output_out,
  output logic modulated_output_oe_out,
  // interrupt
  output logic irq_out
);
  // ==========================================================
  // register storage
  // ==========================================================
  logic [1:0] clk_sel; // counter clock selection
  logic wrap_ie; // wrap event enable
  logic match_ie; // match event enable
  logic wrap_flag; // sticky, cleared by reading its register
  logic match_flag; // sticky, cleared by reading its register
  logic [11:0] reload_value; // reload value
  logic [11:0] duty_value; // duty_compare_value as written
  logic dc_lock; // comparison held off between byte writes
  logic output_drive_enable; // routes the waveform to the pin
  logic output_invert; // polarity of the waveform
  logic [1:0] irq_status; // sticky event bits
  logic [1:0] irq_mask; // per event mask

  // ==========================================================
  // bus channel state
  // ==========================================================
  logic aw_full; // write address held
  logic [9:0] aw_idx; // held write index
  logic w_full; // write data held
  logic [7:0] w_byte; // held low data byte
  logic w_lane; // held strobe of byte lane zero

  // ==========================================================
  // counter clock and core
  // ==========================================================
  wire ms_pulse; // one cycle per timebase rising edge
  wire [11:0] count_value; // live count
  wire wrap_evt; // overflow event
  wire match_evt; // equality event
  wire pwm_raw; // waveform before polarity

  // the timebase comes from another domain, so it is resynchronised
  arpt_sync u_sync (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .level_in(ms_tick_in),
    .pulse_out(ms_pulse)
  );

  // off and the reserved code both stop the counter
  wire sel_ms = (clk_sel == arpt_pkg::CK_MS); // see [R16]
  wire sel_cpu = (clk_sel == arpt_pkg::CK_CPU); // see [R16]
  wire tick = (sel_ms & ms_pulse) | sel_cpu; // see [R1]

  arpt_core u_core (
    .clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .ce_in(ce_in),
    .tick_in(tick),
    .reload_in(reload_value),
    .duty_in(duty_value),
    .lock_in(dc_lock),
    .drive_in(output_drive_enable),
    .count_out(count_value),
    .wrap_out(wrap_evt),
    .match_out(match_evt),
    .pwm_out(pwm_raw)
  );

  // ==========================================================
  // write channel
  // ==========================================================
  wire aw_hs = s_axi_awvalid_in & s_axi_awready_out; // address taken
  wire w_hs = s_axi_wvalid_in & s_axi_wready_out; // data taken
  wire b_hs = s_axi_bvalid_out & s_axi_bready_in; // response taken
  wire wr_go = aw_full & w_full & ~s_axi_bvalid_out; // perform write
  wire wr_en = wr_go & w_lane; // only byte lane zero carries data

  // write index decode
  wire wr_tcs = wr_en & (aw_idx == arpt_pkg::IDX_TCS);
  wire wr_rvh = wr_en & (aw_idx == arpt_pkg::IDX_RVH);
  wire wr_rvl = wr_en & (aw_idx == arpt_pkg::IDX_RVL);
  wire wr_oec = wr_en & (aw_idx == arpt_pkg::IDX_OEC);
  wire wr_ocs = wr_en & (aw_idx == arpt_pkg::IDX_OCS);
  wire wr_dch = wr_en & (aw_idx == arpt_pkg::IDX_DCH);
  wire wr_dcl = wr_en & (aw_idx == arpt_pkg::IDX_DCL);
  wire wr_ist = wr_en & (aw_idx == arpt_pkg::IDX_IST);
  wire wr_imk = wr_en & (aw_idx == arpt_pkg::IDX_IMK);
  // read-only and writable indices answer okay, the rest slverr
  wire wr_known = (aw_idx == arpt_pkg::IDX_CVH) | (aw_idx == arpt_pkg::IDX_CVL)
                | (aw_idx == arpt_pkg::IDX_TCS) | (aw_idx == arpt_pkg::IDX_RVH)
                | (aw_idx == arpt_pkg::IDX_RVL) | (aw_idx == arpt_pkg::IDX_OEC)
                | (aw_idx == arpt_pkg::IDX_OCS) | (aw_idx == arpt_pkg::IDX_DCH)
                | (aw_idx == arpt_pkg::IDX_DCL) | (aw_idx == arpt_pkg::IDX_IST)
                | (aw_idx == arpt_pkg::IDX_IMK);

  // address side: hold until the response is accepted
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_awready_out <= 1'b1;
      aw_full <= 1'b0;
      aw_idx <= 10'h000;
    end else if (ce_in) begin
      if (aw_hs) begin
        s_axi_awready_out <= 1'b0;
        aw_full <= 1'b1;
        aw_idx <= s_axi_awaddr_in[11:2];
      end else if (wr_go) begin
        aw_full <= 1'b0;
      end else if (b_hs) begin
        s_axi_awready_out <= 1'b1;
      end
    end
  end

  // data side: only the low byte matters, the registers are eight bits
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_wready_out <= 1'b1;
      w_full <= 1'b0;
      w_byte <= arpt_pkg::RST_BYTE;
      w_lane <= 1'b0;
    end else if (ce_in) begin
      if (w_hs) begin
        s_axi_wready_out <= 1'b0;
        w_full <= 1'b1;
        w_byte <= s_axi_wdata_in[7:0];
        w_lane <= s_axi_wstrb_in[0];
      end else if (wr_go) begin
        w_full <= 1'b0;
      end else if (b_hs) begin
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // response once both halves are in
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= arpt_pkg::RESP_OKAY;
    end else if (ce_in) begin
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= wr_known ? arpt_pkg::RESP_OKAY : arpt_pkg::RESP_SLVERR;
      end else if (b_hs) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel
  // ==========================================================
  wire ar_hs = s_axi_arvalid_in & s_axi_arready_out; // read taken
  wire r_hs = s_axi_rvalid_out & s_axi_rready_in; // data taken
  wire [9:0] rd_idx = s_axi_araddr_in[11:2]; // read index
  wire rd_clr_tcs = ar_hs & (rd_idx == arpt_pkg::IDX_TCS); // clears wrap flag
  wire rd_clr_ocs = ar_hs & (rd_idx == arpt_pkg::IDX_OCS); // clears match flag

  // read data images; reserved bits are zero
  wire [7:0] img_tcs = {3'h0, clk_sel, wrap_flag, wrap_ie, match_ie};
  wire [7:0] img_cvh = {4'h0, count_value[11:8]}; // see [R2]
  wire [7:0] img_cvl = count_value[7:0]; // see [R2]
  wire [7:0] img_rvh = {4'h0, reload_value[11:8]};
  wire [7:0] img_rvl = reload_value[7:0];
  wire [7:0] img_oec = {7'h00, output_drive_enable};
  wire [7:0] img_ocs = {6'h00, output_invert, match_flag};
  wire [7:0] img_dch = {4'h0, duty_value[11:8]};
  wire [7:0] img_dcl = duty_value[7:0];
  wire [7:0] img_ist = {6'h00, irq_status};
  wire [7:0] img_imk = {6'h00, irq_mask};
  // selection of the addressed image
  wire rd_known = (rd_idx == arpt_pkg::IDX_TCS) | (rd_idx == arpt_pkg::IDX_CVH)
                | (rd_idx == arpt_pkg::IDX_CVL) | (rd_idx == arpt_pkg::IDX_RVH)
                | (rd_idx == arpt_pkg::IDX_RVL) | (rd_idx == arpt_pkg::IDX_OEC)
                | (rd_idx == arpt_pkg::IDX_OCS) | (rd_idx == arpt_pkg::IDX_DCH)
                | (rd_idx == arpt_pkg::IDX_DCL) | (rd_idx == arpt_pkg::IDX_IST)
                | (rd_idx == arpt_pkg::IDX_IMK);
  wire [7:0] rd_byte =
      (rd_idx == arpt_pkg::IDX_TCS) ? img_tcs :
      (rd_idx == arpt_pkg::IDX_CVH) ? img_cvh :
      (rd_idx == arpt_pkg::IDX_CVL) ? img_cvl :
      (rd_idx == arpt_pkg::IDX_RVH) ? img_rvh :
      (rd_idx == arpt_pkg::IDX_RVL) ? img_rvl :
      (rd_idx == arpt_pkg::IDX_OEC) ? img_oec :
      (rd_idx == arpt_pkg::IDX_OCS) ? img_ocs :
      (rd_idx == arpt_pkg::IDX_DCH) ? img_dch :
      (rd_idx == arpt_pkg::IDX_DCL) ? img_dcl :
      (rd_idx == arpt_pkg::IDX_IST) ? img_ist :
      (rd_idx == arpt_pkg::IDX_IMK) ? img_imk : arpt_pkg::RST_BYTE;

  // data is captured when the address is taken, so a read sees the flag
  // as it stood before its own clearing
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0000_0000;
      s_axi_rresp_out <= arpt_pkg::RESP_OKAY;
    end else if (ce_in) begin
      if (ar_hs) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= {24'h000000, rd_byte};
        s_axi_rresp_out <= rd_known ? arpt_pkg::RESP_OKAY : arpt_pkg::RESP_SLVERR;
      end else if (r_hs) begin
        s_axi_arready_out <= 1'b1;
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control registers
  // ==========================================================
  // clock selection and event enables; wrap flag is not writable
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_sel <= arpt_pkg::CK_OFF; // see [R12]
      wrap_ie <= 1'b0;
      match_ie <= 1'b0;
    end else if (ce_in && wr_tcs) begin
      clk_sel <= w_byte[arpt_pkg::TCS_CK_LSB +: 2]; // see [R16]
      wrap_ie <= w_byte[arpt_pkg::TCS_WRAP_IE];
      match_ie <= w_byte[arpt_pkg::TCS_MATCH_IE];
    end
  end

  // reload bytes; upper nibble of the high byte is dropped
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reload_value <= arpt_pkg::RST_WORD; // see [R12]
    end else if (ce_in) begin
      if (wr_rvh) begin
        reload_value[11:8] <= w_byte[3:0]; // see [R5]
      end
      if (wr_rvl) begin
        reload_value[7:0] <= w_byte; // see [R5]
      end
    end
  end

  // duty bytes reach compare mode at once, drive mode at the next wrap; a high write locks the compare
  // until the low write, so compare mode never matches a half-written value
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      duty_value <= arpt_pkg::RST_WORD; // see [R12]
      dc_lock <= 1'b0;
    end else if (ce_in) begin
      if (wr_dch) begin
        duty_value[11:8] <= w_byte[3:0];
        dc_lock <= 1'b1; // see [R14]
      end
      if (wr_dcl) begin
        duty_value[7:0] <= w_byte;
        dc_lock <= 1'b0; // see [R14]
      end
    end
  end

  // output enable and polarity
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      output_drive_enable <= 1'b0; // see [R12]
      output_invert <= 1'b0; // see [R8]
    end else if (ce_in) begin
      if (wr_oec) begin
        output_drive_enable <= w_byte[arpt_pkg::OEC_DRIVE]; // see [R10]
      end
      if (wr_ocs) begin
        output_invert <= w_byte[arpt_pkg::OCS_INVERT]; // see [R8]
      end
    end
  end

  // ==========================================================
  // flags and interrupt
  // ==========================================================
  // read clears, but an event in the same cycle keeps the flag set
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wrap_flag <= 1'b0;
      match_flag <= 1'b0;
    end else if (ce_in) begin
      wrap_flag <= wrap_evt | (wrap_flag & ~rd_clr_tcs); // see [R15]
      match_flag <= match_evt | (match_flag & ~rd_clr_ocs); // see [R9]
    end
  end

  // sticky status with write one to clear; set wins the tie
  wire [1:0] evt_vec = {wrap_evt, match_evt};
  wire [1:0] ist_clr = wr_ist ? w_byte[1:0] : 2'h0;
  wire [1:0] ev_en = {wrap_ie, match_ie}; // per event enable in control
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_status <= arpt_pkg::RST_IRQ;
      irq_mask <= arpt_pkg::RST_IRQ;
    end else if (ce_in) begin
      irq_status <= evt_vec | (irq_status & ~ist_clr);
      if (wr_imk) begin
        irq_mask <= w_byte[1:0];
      end
    end
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  // pin released when drive is off; one cycle behind the core
  always_ff @(posedge ref_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      modulated_output_out <= 1'b0;
      modulated_output_oe_out <= 1'b0;
      irq_out <= 1'b0;
    end else if (ce_in) begin
      modulated_output_out <= output_drive_enable & (pwm_raw ^ output_invert); // see [R10]
      modulated_output_oe_out <= output_drive_enable; // see [R10]
      irq_out <= |(irq_status & irq_mask & ev_en);
    end
  end
endmodule : arpt_top
`default_nettype wire

// ---- include/arpt_pkg.sv ----
`default_nettype none
// ==========================================================
// register map, field layout and encodings of the timer
// ==========================================================
package arpt_pkg;
  // register indices; byte address is four times the index
  localparam logic [9:0] IDX_TCS = 10'h00D; // timer_control_status
  localparam logic [9:0] IDX_CVH = 10'h00E; // count_value_high
  localparam logic [9:0] IDX_CVL = 10'h00F; // count_value_low
  localparam logic [9:0] IDX_RVH = 10'h010; // reload_value_high
  localparam logic [9:0] IDX_RVL = 10'h011; // reload_value_low
  localparam logic [9:0] IDX_OEC = 10'h012; // output_enable_control
  localparam logic [9:0] IDX_OCS = 10'h013; // output_control_status
  localparam logic [9:0] IDX_DCH = 10'h017; // duty_compare_high
  localparam logic [9:0] IDX_DCL = 10'h018; // duty_compare_low
  localparam logic [9:0] IDX_IST = 10'h020; // interrupt status, write one to clear
  localparam logic [9:0] IDX_IMK = 10'h021; // interrupt mask
  // timer_control_status fields
  localparam int TCS_CK_LSB = 3;
  localparam int TCS_WRAP = 2;
  localparam int TCS_WRAP_IE = 1;
  localparam int TCS_MATCH_IE = 0;
  // output_control_status fields
  localparam int OCS_INVERT = 1;
  localparam int OCS_MATCH = 0;
  // output_enable_control field
  localparam int OEC_DRIVE = 0;
  // interrupt status and mask layout
  localparam int IRQ_MATCH = 0;
  localparam int IRQ_WRAP = 1;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [11:0] RST_WORD = 12'h000;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // counter limit before a reload
  localparam logic [11:0] COUNT_MAX = 12'hFFF;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // counter clock selection
  typedef enum logic [1:0] {
    CK_OFF = 2'h0,
    CK_MS = 2'h1,
    CK_CPU = 2'h2,
    CK_RSVD = 2'h3
  } arpt_clk_sel_t;
endpackage : arpt_pkg
`default_nettype wire

// ---- rtl/arpt_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// two-stage synchroniser with rising edge pulse
// ==========================================================
module arpt_sync (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // asynchronous level and its edge
  input wire logic level_in,
  output logic pulse_out
);
  logic meta; // first stage, read only by the second
  logic stable; // second stage
  logic prev; // delayed copy for edge detection

  // shift chain; the edge detector looks only past the first stage
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else if (ce_in) begin
      meta <= level_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign pulse_out = ce_in & stable & ~prev;
endmodule : arpt_sync
`default_nettype wire

// ---- rtl/arpt_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// counter, reload, shadow duty and waveform generation
// ==========================================================
module arpt_core (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // counter clock tick
  input wire logic tick_in,
  // configuration
  input wire logic [11:0] reload_in,
  input wire logic [11:0] duty_in,
  input wire logic lock_in,
  input wire logic drive_in,
  // state and events
  output logic [11:0] count_out,
  output logic wrap_out,
  output logic match_out,
  output logic pwm_out
);
  logic [11:0] count; // free running count value
  logic [11:0] shadow; // active duty copy, refreshed at wrap
  logic pwm; // raw waveform before polarity

  // reload at the top instead of rolling to zero
  wire at_top = (count == arpt_pkg::COUNT_MAX);
  wire [11:0] next_count = at_top ? reload_in : count + 12'h001; // see [R4]
  // shadow takes the duty value even while locked
  wire [11:0] next_shadow = at_top ? duty_in : shadow; // see [R13]
  // drive mode compares the shadow, compare mode the written value
  wire [11:0] target = drive_in ? next_shadow : duty_in; // see [R7]
  wire wrap = ce_in & tick_in & at_top; // see [R15]
  // zero is the reset value, so compare mode ignores it
  wire nonzero = (duty_in != arpt_pkg::RST_WORD);
  wire hit = ce_in & tick_in & ~lock_in & (next_count == target)
             & (drive_in | nonzero); // see [R14]

  // count advances one step per tick
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= arpt_pkg::RST_WORD; // see [R2]
      shadow <= arpt_pkg::RST_WORD;
    end else if (ce_in && tick_in) begin
      count <= next_count; // see [R1]
      shadow <= next_shadow; // see [R13]
    end
  end

  // high at wrap, low at match; match wins so equal values give a flat line
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwm <= 1'b0;
    end else if (hit && drive_in) begin
      pwm <= 1'b0; // see [R13]
    end else if (wrap) begin
      pwm <= 1'b1; // see [R13]
    end
  end

  assign count_out = count;
  assign wrap_out = wrap;
  assign match_out = hit;
  assign pwm_out = pwm;
endmodule : arpt_core
`default_nettype wire

// ---- tb/arpt_top_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// port checker for the timer's bus and pin
// ==========================================================
module arpt_mon (
  // clock, reset, enable
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic ce_in,
  // bus handshakes
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [11:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic [1:0] s_axi_rresp_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // pin
  input wire logic modulated_output_out,
  input wire logic modulated_output_oe_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!nrst_in);
  // both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out && ce_in;
  endsequence
  // one cycle holding, then the answer
  sequence s_wr_answer;
    !s_axi_bvalid_out ##1 s_axi_bvalid_out;
  endsequence
  a_wr_answer: assert property (s_wr_take |=> s_wr_answer)
    else $error("write answer late");
  a_aw_busy: assert property (s_wr_take |=> !s_axi_awready_out [*2])
    else $error("second write accepted early");
  a_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out && ce_in |=> s_axi_rvalid_out)
    else $error("read answer late");
  a_bresp_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("read data dropped");
  a_rdata_upper: assert property (s_axi_rvalid_out
    |-> s_axi_rdata_out[31:8] == 24'h000000) else $error("upper read bits set");
  a_unmapped_err: assert property (s_axi_arvalid_in && s_axi_arready_out
    && s_axi_araddr_in[11:2] > arpt_pkg::IDX_IMK
    |=> s_axi_rresp_out == arpt_pkg::RESP_SLVERR) else $error("unmapped read not refused");
  a_pin_release: assert property (!modulated_output_oe_out |-> !modulated_output_out)
    else $error("pin driven while released");
endmodule : arpt_mon
bind arpt_top arpt_mon mon_u (.*);
`default_nettype wire

// ---- tb/arpt_top_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module arpt_top_test;
  // ==========================================================
  // signals named as the ports, joined by name
  // ==========================================================
  logic ref_clk_in, nrst_in, ce_in, ms_tick_in;
  logic [11:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
  logic s_axi_arvalid_in, s_axi_rready_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd, rd2;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out;
  logic s_axi_arready_out, s_axi_rvalid_out, done;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rsp;
  logic modulated_output_out, modulated_output_oe_out, irq_out;
  int err_total, tests_run, hi_cnt;
  arpt_top dut_u (.*);
  // free running 10 mhz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  // ==========================================================
  // helpers
  // ==========================================================
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask : cyc
  // one write; each channel released at the edge it is taken
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    @(posedge ref_clk_in);
    s_axi_awaddr_in <= {i, 2'b00};
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge ref_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      done = s_axi_bvalid_out;
    end
    rsp = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
  endtask : wr
  // one read; data taken at the handshake edge
  task automatic rdx(input logic [9:0] i);
    @(posedge ref_clk_in);
    s_axi_araddr_in <= {i, 2'b00};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    done = 1'b0;
    while (!done) begin
      @(posedge ref_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      done = s_axi_rvalid_out;
    end
    rd = s_axi_rdata_out;
    rsp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
  endtask : rdx
  task automatic rc(input logic [9:0] i, input logic [7:0] e);
    rdx(i);
    chk(rd, {24'h000000, e});
  endtask : rc
  // high cycles of the pin over two full periods
  task automatic measure(input int e);
    hi_cnt = 0;
    repeat (4096) begin
      @(posedge ref_clk_in);
      if (modulated_output_out === 1'b1) hi_cnt++;
    end
    chk(hi_cnt, e);
  endtask : measure
  task give_verdict;
    $display("compared %0d, mismatched %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // watchdog, about twice the expected run
  initial begin
    #4000000;
    err_total++;
    give_verdict();
  end
  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    {nrst_in, ms_tick_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = '0;
    {s_axi_arvalid_in, s_axi_rready_in, s_axi_awaddr_in, s_axi_araddr_in} = '0;
    s_axi_wdata_in = '0;
    ce_in = 1'b1;
    s_axi_wstrb_in = 4'hF;
    err_total = 0;
    tests_run = 0;
    cyc(12);
    nrst_in <= 1'b1;
    for (int k = 13; k < 34; k++) rc(k[9:0], 8'h00);
    rdx(10'h3FF);
    chk({30'h0, rsp}, {30'h0, arpt_pkg::RESP_SLVERR});
    $display("reset values done");
    wr(arpt_pkg::IDX_RVH, 8'h0F);
    rc(arpt_pkg::IDX_RVH, 8'h0F);
    wr(arpt_pkg::IDX_CVH, 8'h0F);
    rc(arpt_pkg::IDX_CVH, 8'h00);
    wr(arpt_pkg::IDX_OEC, 8'h01);
    rc(arpt_pkg::IDX_OEC, 8'h01);
    cyc(2);
    chk({31'h0, modulated_output_oe_out}, 32'h1);
    wr(arpt_pkg::IDX_OEC, 8'h00);
    wr(arpt_pkg::IDX_OCS, 8'h03);
    rc(arpt_pkg::IDX_OCS, 8'h02);
    $display("access kinds done");
    // reload 0x800 on the cpu clock: first wrap near 4096 ticks
    wr(arpt_pkg::IDX_RVH, 8'h08);
    wr(arpt_pkg::IDX_RVL, 8'h00);
    wr(arpt_pkg::IDX_TCS, 8'h10);
    cyc(4200);
    rc(arpt_pkg::IDX_TCS, 8'h14);
    rc(arpt_pkg::IDX_TCS, 8'h10);
    rdx(arpt_pkg::IDX_CVH);
    chk({31'h0, rd[3]}, 32'h1);
    // stop and reserved codes hold the count
    for (int c = 0; c < 4; c += 3) begin
      wr(arpt_pkg::IDX_TCS, 8'(c << 3));
      rdx(arpt_pkg::IDX_CVL);
      rd2 = rd;
      cyc(20);
      rc(arpt_pkg::IDX_CVL, rd2[7:0]);
    end
    // a low clock enable freezes the running counter: two ticks before, one after
    wr(arpt_pkg::IDX_TCS, 8'h10);
    rdx(arpt_pkg::IDX_CVL);
    rd2 = rd;
    ce_in <= 1'b0;
    cyc(20);
    ce_in <= 1'b1;
    rc(arpt_pkg::IDX_CVL, rd2[7:0] + 8'h03);
    wr(arpt_pkg::IDX_TCS, 8'h08);
    rdx(arpt_pkg::IDX_CVL);
    rd2 = rd;
    repeat (3) begin
      ms_tick_in <= 1'b1;
      cyc(4);
      ms_tick_in <= 1'b0;
      cyc(4);
    end
    cyc(4);
    rc(arpt_pkg::IDX_CVL, rd2[7:0] + 8'h03);
    $display("counter done");
    // compare use with the drive off, interrupt masked first
    wr(arpt_pkg::IDX_TCS, 8'h11);
    wr(arpt_pkg::IDX_DCH, 8'h08);
    wr(arpt_pkg::IDX_DCL, 8'h80);
    wr(arpt_pkg::IDX_IMK, 8'h00);
    cyc(2100);
    chk({31'h0, irq_out}, 32'h0);
    wr(arpt_pkg::IDX_IMK, 8'h01);
    cyc(2);
    chk({31'h0, irq_out}, 32'h1);
    rc(arpt_pkg::IDX_OCS, 8'h03);
    rc(arpt_pkg::IDX_OCS, 8'h02);
    wr(arpt_pkg::IDX_IST, 8'h01);
    cyc(2);
    chk({31'h0, irq_out}, 32'h0);
    $display("compare done");
    // waveform: high from wrap at 0x800 to match at 0x900
    wr(arpt_pkg::IDX_OEC, 8'h01);
    wr(arpt_pkg::IDX_OCS, 8'h00);
    wr(arpt_pkg::IDX_DCH, 8'h09);
    wr(arpt_pkg::IDX_DCL, 8'h00);
    cyc(2100);
    measure(512);
    wr(arpt_pkg::IDX_OCS, 8'h02);
    cyc(10);
    measure(3584);
    $display("waveform done");
    give_verdict();
  end
endmodule : arpt_top_test
`default_nettype wire
